/* sdstl_pkg.sv */
// shared constants and types for the settle detector and soft travel limiter
package sdstl_pkg;
  localparam int POS_W = 32;
  localparam int VEL_W = 24;
  localparam int CUR_W = 16;
  localparam int TMR_W = 32;
  localparam int CLOCK_MHZ = 250;
  localparam int SCAN_US = 2000;
  localparam int SCAN_CYC = SCAN_US * CLOCK_MHZ;
  localparam int SCAN_CNT_W = 20;
  localparam int PCT_FULL = 10000;
  localparam int LOOKAHEAD_SHIFT = 9;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_BAND      = 8'h04;
  localparam logic [7:0] ADDR_DWELL     = 8'h08;
  localparam logic [7:0] ADDR_NEGLIM    = 8'h0c;
  localparam logic [7:0] ADDR_POSLIM    = 8'h10;
  localparam logic [7:0] ADDR_ANAMIN    = 8'h14;
  localparam logic [7:0] ADDR_ANAMAX    = 8'h18;
  localparam logic [7:0] ADDR_PCT       = 8'h1c;
  localparam logic [7:0] ADDR_LIMVEL    = 8'h20;
  localparam logic [7:0] ADDR_CURRENT   = 8'h24;
  localparam logic [7:0] ADDR_BOOSTTIME = 8'h28;
  localparam logic [7:0] ADDR_STATUS    = 8'h2c;
  localparam logic [31:0] UNMAPPED_DATA = 32'hdeadbeef;

  // control register fields
  localparam int CTRL_NEG_EN   = 0;
  localparam int CTRL_POS_EN   = 1;
  localparam int CTRL_PCT_MODE = 2;
  localparam int CTRL_REVERSE  = 3;

  // active motion mode
  typedef enum logic [3:0] {
    SDSTL_MODE_POSITION = 4'h0,
    SDSTL_MODE_VELOCITY = 4'h1,
    SDSTL_MODE_TORQUE   = 4'h2,
    SDSTL_MODE_JOG      = 4'h3,
    SDSTL_MODE_HELD     = 4'h4,
    SDSTL_MODE_PULSE    = 4'h5,
    SDSTL_MODE_DEDIC    = 4'h6,
    SDSTL_MODE_HOME     = 4'h7
  } sdstl_mode_e;

  // restricted-mode current phase, one-hot
  typedef enum logic [2:0] {
    SDSTL_CUR_FREE  = 3'b001,
    SDSTL_CUR_BOOST = 3'b010,
    SDSTL_CUR_SUST  = 3'b100
  } sdstl_cur_e;

  typedef struct packed {
    logic signed [POS_W-1:0] cmdPos;
    logic signed [POS_W-1:0] actPos;
    logic signed [VEL_W-1:0] cmdVel;
    logic signed [VEL_W-1:0] accelRate;
    sdstl_mode_e             mode;
    logic                    analogPosMode;
  } sdstl_motion_s;

  typedef struct packed {
    logic heldActive;
    logic pulseStart;
    logic pulseDone;
    logic stopReq;
    logic disableReq;
    logic jogReverse;
    logic dedicatedMove;
    logic alternateSel;
    logic hardStop;
  } sdstl_event_s;

  typedef struct packed {
    logic signed [VEL_W-1:0] velCap;
    logic                    velCapEn;
    logic [CUR_W-1:0]        curCap;
    logic                    curCapEn;
    logic signed [VEL_W-1:0] decelRate;
    logic                    decelReq;
    logic                    holdDeviation;
  } sdstl_limit_s;
endpackage : sdstl_pkg

/* sdstl_top.sv */
// settle detector and direction-sensitive software travel limiter
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// R1: band accepts error up to band value on either side of command.
// R2: settled only when error in band for dwell time and command velocity zero.
// R3: one shared band and dwell setting judges all completions.
// R4: leaving band or nonzero velocity restarts dwell and drops settled.
// R5: negative and positive limits enable separately, all modes.
// R6: crossing predicted from velocity every two milliseconds.
// R7: predicted crossing decelerates at active mode's rate.
// R8: command outside range enters restricted mode with limit settings.
// R9: zero limit velocity stops near limit; nonzero runs to hard stop.
// R10: hard stop allows boost current for set time, then sustained current.
// R11: deviation held to keep current cap against hard stop.
// R12: restrictions only toward the active limit; reverse motion normal.
// R13: torque modes drop velocity cap but keep current caps.
// R14: limits inactive until reference established.
// R15: percent option derives limits from analog minimum and maximum.
// R16: velocity, torque, position and jog modes exit on reverse command.
// R17: held move aborts on release, then any mode may exit.
// R18: pulse move stays active to completion, blocking other pulse moves.
// R19: latched move ends on held move, stop, disable, jog, dedicated, alternate.
// R20: boost and sustained currents must exceed homing current cap; not checked here, both values are used as written.
module sdstl_top
  import sdstl_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // motion side
  input  wire sdstl_motion_s motion,
  input  wire sdstl_event_s  events,
  input  wire logic          referenceOk,
  output sdstl_limit_s       limitCmd,
  output logic               targetSettled,
  output logic               restricted,
  output logic               pulseBlock,
  output logic               abortMove
);

  logic        [3:0]       ctrl;
  logic        [POS_W-1:0] band;
  logic        [TMR_W-1:0] dwell;
  logic signed [POS_W-1:0] negAbs, posAbs, anaMin, anaMax;
  logic        [15:0]      negPct, posPct;
  logic signed [VEL_W-1:0] limVel;
  logic        [CUR_W-1:0] boostAmps, sustAmps;
  logic        [TMR_W-1:0] boostTime;
  logic                    ack;

  // one wait state per access keeps the read path registered
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) ack <= 1'b0;
    else       ack <= (read | write) & ~ack;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) waitrequest <= 1'b1;
    else       waitrequest <= ~((read | write) & ~ack);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl <= 4'h0; band <= '0; dwell <= '0; negAbs <= '0; posAbs <= '0;
      anaMin <= '0; anaMax <= '0; negPct <= 16'h0000; posPct <= 16'(PCT_FULL);
      limVel <= '0; boostAmps <= '0; sustAmps <= '0; boostTime <= '0;
    end else if (write && ack) begin
      unique case (address)
        ADDR_CTRL:      ctrl <= writedata[3:0];
        ADDR_BAND:      band <= writedata;
        ADDR_DWELL:     dwell <= writedata;
        ADDR_NEGLIM:    negAbs <= writedata;
        ADDR_POSLIM:    posAbs <= writedata;
        ADDR_ANAMIN:    anaMin <= writedata;
        ADDR_ANAMAX:    anaMax <= writedata;
        ADDR_PCT:       {posPct, negPct} <= writedata;
        ADDR_LIMVEL:    limVel <= writedata[VEL_W-1:0];
        ADDR_CURRENT:   {sustAmps, boostAmps} <= writedata;
        ADDR_BOOSTTIME: boostTime <= writedata;
        default: ;
      endcase
    end
  end

  // settle detector
  logic signed [POS_W-1:0] posErr;
  logic        [POS_W-1:0] absErr;
  logic                    inBand;
  logic        [TMR_W-1:0] dwellCnt;
  assign posErr = motion.cmdPos - motion.actPos;
  assign absErr = posErr[POS_W-1] ? POS_W'(-posErr) : posErr;
  assign inBand = (absErr <= band);                                   // [R1] [R3]

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) dwellCnt <= '0;
    else if (!inBand || motion.cmdVel != '0) dwellCnt <= '0;          // [R4]
    else if (dwellCnt < dwell) dwellCnt <= dwellCnt + 1'b1;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) targetSettled <= 1'b0;
    else targetSettled <= inBand && (motion.cmdVel == '0) && (dwellCnt >= dwell); // [R2] [R4]
  end

  // effective limits
  function automatic logic signed [POS_W-1:0] pctPos(input logic [15:0] p);
    logic signed [63:0] span;
    span = 64'(anaMax) - 64'(anaMin);
    pctPos = POS_W'(64'(anaMin) + (span * $signed({48'h0, p})) / PCT_FULL);
  endfunction : pctPos

  logic signed [POS_W-1:0] negLim, posLim;
  assign negLim = ctrl[CTRL_PCT_MODE] ? pctPos(negPct) : negAbs;      // [R15]
  assign posLim = ctrl[CTRL_PCT_MODE] ? pctPos(posPct) : posAbs;      // [R15]

  logic negOn, posOn;
  assign negOn = ctrl[CTRL_NEG_EN] & referenceOk;                     // [R5] [R14]
  assign posOn = ctrl[CTRL_POS_EN] & referenceOk;                     // [R5] [R14]

  // scan timer and look-ahead
  logic [SCAN_CNT_W-1:0] scanCnt;
  logic                  scanTick;
  assign scanTick = (scanCnt == SCAN_CNT_W'(SCAN_CYC - 1));
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)         scanCnt <= '0;
    else if (scanTick) scanCnt <= '0;                                 // [R6]
    else               scanCnt <= scanCnt + 1'b1;
  end

  logic signed [POS_W-1:0] predPos;
  assign predPos = motion.cmdPos + POS_W'(64'(motion.cmdVel) <<< LOOKAHEAD_SHIFT);
  logic towardNeg, towardPos;
  assign towardNeg = motion.cmdVel < 0;
  assign towardPos = motion.cmdVel > 0;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) limitCmd.decelReq <= 1'b0;
    else if (scanTick)
      limitCmd.decelReq <= (negOn && towardNeg && predPos <= negLim) ||
                           (posOn && towardPos && predPos >= posLim); // [R6] [R12]
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) limitCmd.decelRate <= '0;
    else       limitCmd.decelRate <= motion.accelRate;                // [R7]
  end

  // restricted mode: side latched at entry, exit by mode-dependent recovery
  logic outNeg, outPos, sideNeg, sidePos, latchPulse, reverseCmd;
  sdstl_mode_e entryMode;
  assign outNeg = negOn && motion.cmdPos < negLim;
  assign outPos = posOn && motion.cmdPos > posLim;
  assign reverseCmd = (sideNeg && towardPos) || (sidePos && towardNeg);

  function automatic logic endsLatch(input sdstl_event_s e, input logic rev);
    endsLatch = e.heldActive | e.stopReq | e.disableReq | (e.jogReverse & rev) |
                e.dedicatedMove | e.alternateSel;
  endfunction : endsLatch

  logic exitOk;
  always_comb begin
    exitOk = 1'b0;
    unique case (entryMode)
      SDSTL_MODE_PULSE: exitOk = !latchPulse && reverseCmd;           // [R18]
      SDSTL_MODE_HELD:  exitOk = !events.heldActive && reverseCmd;    // [R17]
      default:          exitOk = reverseCmd;                          // [R16]
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sideNeg <= 1'b0; sidePos <= 1'b0; entryMode <= SDSTL_MODE_POSITION;
    end else if (!sideNeg && !sidePos) begin
      sideNeg <= outNeg;                                              // [R8]
      sidePos <= outPos && !outNeg;
      entryMode <= motion.mode;
    end else if ((exitOk && !outNeg && !outPos) || !referenceOk ||
                 (sideNeg && !ctrl[CTRL_NEG_EN]) || (sidePos && !ctrl[CTRL_POS_EN])) begin
      sideNeg <= 1'b0; sidePos <= 1'b0;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) restricted <= 1'b0;
    else       restricted <= sideNeg | sidePos;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) latchPulse <= 1'b0;
    else if (endsLatch(events, ctrl[CTRL_REVERSE]) || events.pulseDone) latchPulse <= 1'b0; // [R19]
    else if ((outNeg || outPos) && motion.mode == SDSTL_MODE_PULSE) latchPulse <= 1'b1;  // [R18]
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) pulseBlock <= 1'b0;
    else       pulseBlock <= latchPulse;                              // [R18]
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) abortMove <= 1'b0;
    else abortMove <= (sideNeg || sidePos) && entryMode == SDSTL_MODE_HELD &&
                      motion.mode == SDSTL_MODE_HELD && !events.heldActive; // [R17]
  end

  // caps apply while moving toward the active limit or at zero command velocity
  logic toward, torqueMode;
  assign toward = (sideNeg && !towardPos) || (sidePos && !towardNeg); // [R12]
  assign torqueMode = motion.mode == SDSTL_MODE_TORQUE;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      limitCmd.velCap <= '0; limitCmd.velCapEn <= 1'b0;
    end else begin
      limitCmd.velCapEn <= toward && !torqueMode;                     // [R13] [R9]
      limitCmd.velCap   <= sideNeg ? -limVel : limVel;                // [R9]
    end
  end

  sdstl_cur_e curState;
  logic [TMR_W-1:0] boostCnt;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) curState <= SDSTL_CUR_FREE;
    else if (!toward) curState <= SDSTL_CUR_FREE;
    else begin
      unique case (curState)
        SDSTL_CUR_FREE:  if (events.hardStop) curState <= SDSTL_CUR_BOOST; // [R10]
        SDSTL_CUR_BOOST: if (boostCnt >= boostTime) curState <= SDSTL_CUR_SUST; // [R10]
        SDSTL_CUR_SUST:  curState <= SDSTL_CUR_SUST;
        default:         curState <= SDSTL_CUR_FREE;
      endcase
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) boostCnt <= '0;
    else if (curState != SDSTL_CUR_BOOST) boostCnt <= '0;
    else boostCnt <= boostCnt + 1'b1;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      limitCmd.curCap <= '0; limitCmd.curCapEn <= 1'b0; limitCmd.holdDeviation <= 1'b0;
    end else begin
      limitCmd.curCapEn <= toward;                                    // [R13]
      limitCmd.curCap <= (curState == SDSTL_CUR_SUST) ? sustAmps : boostAmps; // [R10]
      limitCmd.holdDeviation <= toward && curState != SDSTL_CUR_FREE; // [R11]
    end
  end

  // register read-back
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) readdata <= '0;
    else if (read && !ack) begin
      unique case (address)
        ADDR_CTRL:      readdata <= {28'h0, ctrl};
        ADDR_BAND:      readdata <= band;
        ADDR_DWELL:     readdata <= dwell;
        ADDR_NEGLIM:    readdata <= negAbs;
        ADDR_POSLIM:    readdata <= posAbs;
        ADDR_ANAMIN:    readdata <= anaMin;
        ADDR_ANAMAX:    readdata <= anaMax;
        ADDR_PCT:       readdata <= {posPct, negPct};
        ADDR_LIMVEL:    readdata <= 32'(limVel);
        ADDR_CURRENT:   readdata <= {sustAmps, boostAmps};
        ADDR_BOOSTTIME: readdata <= boostTime;
        ADDR_STATUS:    readdata <= {24'h0, curState, latchPulse, sidePos, sideNeg,
                                     targetSettled, restricted};
        default:        readdata <= UNMAPPED_DATA;
      endcase
    end
  end

  // assertions
  settle_needs_still_a: assert property (@(posedge clock) disable iff (!nrst)
    targetSettled |-> $past(motion.cmdVel) == '0) else $error("settled with motion"); // [R2]
  settle_drops_a: assert property (@(posedge clock) disable iff (!nrst)
    !inBand |=> !targetSettled) else $error("settled outside band"); // [R4]
  band_symmetric_a: assert property (@(posedge clock) disable iff (!nrst)
    (posErr == $signed(band) || posErr == -$signed(band)) |-> inBand) else $error("band not symmetric"); // [R1]
  limit_homed_a: assert property (@(posedge clock) disable iff (!nrst)
    !referenceOk |=> ##1 !restricted) else $error("limit before homing"); // [R14]
  sequence boostSeq; curState == SDSTL_CUR_BOOST && boostCnt >= boostTime && toward; endsequence
  boost_expire_a: assert property (@(posedge clock) disable iff (!nrst)
    boostSeq |=> curState == SDSTL_CUR_SUST) else $error("boost did not time out"); // [R10]
  torque_novel_a: assert property (@(posedge clock) disable iff (!nrst)
    torqueMode |=> !limitCmd.velCapEn) else $error("velocity cap in torque mode"); // [R13]
  reverse_free_a: assert property (@(posedge clock) disable iff (!nrst)
    (sideNeg && towardPos) || (sidePos && towardNeg) |=> !limitCmd.curCapEn) else $error("reverse motion capped"); // [R12]
  pulse_block_a: assert property (@(posedge clock) disable iff (!nrst)
    latchPulse |=> pulseBlock) else $error("pulse moves not blocked"); // [R18]
  latch_end_a: assert property (@(posedge clock) disable iff (!nrst)
    (latchPulse && events.stopReq) |=> !latchPulse) else $error("latched move not ended"); // [R19]
  scan_period_a: assert property (@(posedge clock) disable iff (!nrst)
    scanTick |=> !scanTick) else $error("scan tick too frequent"); // [R6]

  // settle detection: the whole still-and-in-band condition must raise the flag
  sequence stillInBand;
    inBand && motion.cmdVel == '0 && dwellCnt >= dwell;
  endsequence
  settle_rise_a: assert property (@(posedge clock) disable iff (!nrst) // [R2]
    stillInBand |=> targetSettled) else $error("settled flag missing");

  // look-ahead result may only move on a scan tick
  decel_on_scan_a: assert property (@(posedge clock) disable iff (!nrst) // [R6]
    !scanTick |=> $stable(limitCmd.decelReq)) else $error("deceleration outside scan");

  // deceleration follows the active mode's ramp
  decel_rate_a: assert property (@(posedge clock) disable iff (!nrst) // [R7]
    1'b1 |=> limitCmd.decelRate == $past(motion.accelRate)) else $error("wrong ramp rate");

  // entry into the restricted mode on the positive side
  restrict_entry_a: assert property (@(posedge clock) disable iff (!nrst) // [R8]
    (!sideNeg && !sidePos && outPos && !outNeg) |=> sidePos) else $error("limit not entered");

  // limit velocity handed on unchanged toward the positive limit
  limvel_cap_a: assert property (@(posedge clock) disable iff (!nrst) // [R9]
    sidePos |=> limitCmd.velCap == $past(limVel)) else $error("wrong velocity cap");

  // a hard stop while heading for the limit starts the boost phase
  boost_entry_a: assert property (@(posedge clock) disable iff (!nrst) // [R10]
    (curState == SDSTL_CUR_FREE && toward && events.hardStop) |=> curState == SDSTL_CUR_BOOST)
    else $error("boost not started");

  // deviation is regulated, not accumulated, once pressing on a stop
  hold_dev_a: assert property (@(posedge clock) disable iff (!nrst) // [R11]
    (toward && curState != SDSTL_CUR_FREE) |=> limitCmd.holdDeviation)
    else $error("deviation not held");

  // current caps stay on in every mode while heading for the limit
  cur_cap_toward_a: assert property (@(posedge clock) disable iff (!nrst) // [R13]
    toward |=> limitCmd.curCapEn) else $error("current cap missing");

  // nothing counts as outside the range before homing or when disabled
  homed_only_a: assert property (@(posedge clock) disable iff (!nrst) // [R14]
    !referenceOk |-> !outNeg && !outPos) else $error("limit active unhomed");
  enable_split_a: assert property (@(posedge clock) disable iff (!nrst) // [R5]
    !ctrl[CTRL_POS_EN] |-> !outPos) else $error("disabled limit active");

  // releasing a held move that caused the limit aborts it
  abort_held_a: assert property (@(posedge clock) disable iff (!nrst) // [R17]
    ((sideNeg || sidePos) && entryMode == SDSTL_MODE_HELD && motion.mode == SDSTL_MODE_HELD &&
     !events.heldActive) |=> abortMove) else $error("held move not aborted");

endmodule : sdstl_top
`default_nettype wire

/* sdstl_load_model.sv */
// motor, load and trajectory generator model facing the limiter
`timescale 1ns/1ns
`default_nettype none
module sdstl_load_model
  import sdstl_pkg::*;
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    nrst,
  // scenario settings
  input  wire logic signed [POS_W-1:0] tgtPos,
  input  wire logic signed [VEL_W-1:0] speed,
  input  wire logic signed [POS_W-1:0] posErr,
  input  wire logic signed [POS_W-1:0] stopPos,
  input  wire sdstl_mode_e             mode,
  // limiter side
  input  wire sdstl_limit_s            limitCmd,
  output sdstl_motion_s                motion,
  output logic                         hardStop
);
  logic signed [POS_W-1:0] pos;
  logic signed [POS_W-1:0] step;
  logic signed [POS_W-1:0] act;
  logic signed [VEL_W-1:0] vel;

  // a cap is obeyed at once; ramping toward it is not modelled
  assign step = (limitCmd.velCapEn && limitCmd.velCap < speed) ? POS_W'(limitCmd.velCap)
                                                               : POS_W'(speed);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pos <= '0;
    end else if (tgtPos - pos > step) begin
      pos <= pos + step;
    end else if (pos - tgtPos > step) begin
      pos <= pos - step;
    end else begin
      pos <= tgtPos;
    end
  end
  assign vel = (pos < tgtPos) ? VEL_W'(step) : (pos > tgtPos) ? -VEL_W'(step) : '0;
  assign act = pos - posErr;
  // the load cannot pass the stop, whatever the command says
  assign hardStop = (act >= stopPos);
  assign motion = '{cmdPos: pos, actPos: hardStop ? stopPos : act, cmdVel: vel,
                    accelRate: VEL_W'(100), mode: mode, analogPosMode: 1'b0};
endmodule : sdstl_load_model
`default_nettype wire

/* settle_detect_soft_travel_limit_test.sv */
// self-checking bench for the settle detector and soft travel limiter
`timescale 1ns/1ns
`default_nettype none
module settle_detect_soft_travel_limit_test
  import sdstl_pkg::*;
;
  logic                    clock, nrst, read, write, referenceOk, hs;
  logic [7:0]              address;
  logic [31:0]             writedata, readdata, rd;
  logic                    waitrequest, targetSettled, restricted, pulseBlock, abortMove;
  logic signed [POS_W-1:0] tgtPos, posErr, stopPos;
  logic signed [VEL_W-1:0] speed;
  sdstl_mode_e             mode;
  sdstl_motion_s           motion;
  sdstl_event_s            evts, events;
  sdstl_limit_s            limitCmd;
  int                      errors, n_checks;

  assign events = evts | {8'h00, hs};
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  sdstl_top DUT (.clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .motion(motion),
    .events(events), .referenceOk(referenceOk), .limitCmd(limitCmd),
    .targetSettled(targetSettled), .restricted(restricted), .pulseBlock(pulseBlock),
    .abortMove(abortMove));
  sdstl_load_model load (.clock(clock), .nrst(nrst), .tgtPos(tgtPos), .speed(speed),
    .posErr(posErr), .stopPos(stopPos), .mode(mode), .limitCmd(limitCmd), .motion(motion),
    .hardStop(hs));

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chkBit(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask : chkBit
  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (waitrequest !== 1'b0 && i < 100);
    rd = readdata;
    if (i >= 100) errors++;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic go(input int t, input int s);
    @(posedge clock);
    tgtPos <= t;
    speed <= VEL_W'(s);
  endtask : go
  task automatic waitBit(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(posedge clock);
    chkBit(s, v);
  endtask : waitBit

  task automatic test_regs();
    bus(1'b0, ADDR_CTRL, '0);
    chk32(rd, 32'h00000000);
    bus(1'b0, ADDR_PCT, '0);
    chk32(rd, 32'h27100000);
    bus(1'b0, ADDR_STATUS, '0);
    chk32(rd, 32'h00000022);
    bus(1'b0, 8'h40, '0);
    chk32(rd, UNMAPPED_DATA);
    bus(1'b1, ADDR_BAND, 32'h0000000a);
    bus(1'b0, ADDR_BAND, '0);
    chk32(rd, 32'h0000000a);
  endtask : test_regs
  task automatic test_settle();
    bus(1'b1, ADDR_DWELL, 32'h00000014);
    posErr <= 32'sd10;
    go(500, 50);
    cyc(22);
    chkBit(targetSettled, 1'b0);
    cyc(20);
    chkBit(targetSettled, 1'b1);
    posErr <= 32'sd11;
    cyc(3);
    chkBit(targetSettled, 1'b0);
    posErr <= -32'sd10;
    cyc(30);
    chkBit(targetSettled, 1'b1);
    go(600, 50);
    cyc(3);
    chkBit(targetSettled, 1'b0);
    posErr <= '0;
  endtask : test_settle
  task automatic test_limits();
    bus(1'b1, ADDR_POSLIM, 32'h000003e8);
    bus(1'b1, ADDR_NEGLIM, 32'hfffffc18);
    bus(1'b1, ADDR_LIMVEL, 32'h00000005);
    bus(1'b1, ADDR_CURRENT, 32'h02000300);
    bus(1'b1, ADDR_BOOSTTIME, 32'h00000028);
    bus(1'b1, ADDR_CTRL, 32'h00000002);
    stopPos <= 32'sd1600;
    go(1500, 50);
    cyc(40);
    chkBit(restricted, 1'b0);
    referenceOk <= 1'b1;
    waitBit(restricted, 1'b1, 400);
    go(3000, 50);
    cyc(3);
    chkBit(limitCmd.velCapEn, 1'b1);
    chk32(32'(limitCmd.velCap), 32'h00000005);
    chk32(32'(limitCmd.decelRate), 32'h00000064);
    waitBit(hs, 1'b1, 100);
    cyc(5);
    chkBit(limitCmd.holdDeviation, 1'b1);
    chk32(32'(limitCmd.curCap), 32'h00000300);
    cyc(50);
    chk32(32'(limitCmd.curCap), 32'h00000200);
    go(0, 50);
    cyc(3);
    chkBit(limitCmd.velCapEn, 1'b0);
    waitBit(restricted, 1'b0, 400);
    go(-1500, 50);
    cyc(70);
    chkBit(restricted, 1'b0);
    mode <= SDSTL_MODE_TORQUE;
    go(1500, 50);
    waitBit(restricted, 1'b1, 400);
    go(3000, 50);
    cyc(3);
    chkBit(limitCmd.velCapEn, 1'b0);
    chkBit(limitCmd.curCapEn, 1'b1);
    go(0, 50);
    waitBit(restricted, 1'b0, 400);
  endtask : test_limits
  task automatic test_held();
    mode <= SDSTL_MODE_HELD;
    evts.heldActive <= 1'b1;
    go(1500, 50);
    waitBit(restricted, 1'b1, 400);
    evts.heldActive <= 1'b0;
    waitBit(abortMove, 1'b1, 5);
    mode <= SDSTL_MODE_POSITION;
    go(0, 50);
    waitBit(restricted, 1'b0, 400);
  endtask : test_held
  // every latch-ending event in turn; the limit now comes from the analog range
  task automatic test_pulse();
    int endBit[6] = '{8, 5, 4, 3, 2, 1};
    bus(1'b1, ADDR_POSLIM, 32'h00100000);
    bus(1'b1, ADDR_ANAMIN, 32'h00000000);
    bus(1'b1, ADDR_ANAMAX, 32'h000007d0);
    bus(1'b1, ADDR_PCT, 32'h13880000);
    bus(1'b1, ADDR_CTRL, 32'h0000000e);
    for (int j = 0; j < 6; j++) begin
      mode <= SDSTL_MODE_PULSE;
      evts <= 9'h080;
      go(1500, 50);
      waitBit(restricted, 1'b1, 400);
      waitBit(pulseBlock, 1'b1, 5);
      evts <= sdstl_event_s'(9'h001 << endBit[j]);
      waitBit(pulseBlock, 1'b0, 5);
      evts <= '0;
      mode <= SDSTL_MODE_POSITION;
      go(0, 50);
      waitBit(restricted, 1'b0, 400);
    end
  endtask : test_pulse

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    errors = 0;
    n_checks = 0;
    {nrst, read, write, referenceOk} = 4'h0;
    address = '0;
    writedata = '0;
    {tgtPos, posErr} = '0;
    stopPos = 32'sh7fffffff;
    speed = 24'sd50;
    mode = SDSTL_MODE_POSITION;
    evts = '0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    test_regs();
    test_settle();
    test_limits();
    test_held();
    test_pulse();
    print_verdict();
  end
  // the whole run needs a few hundred cycles
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    print_verdict();
  end
endmodule : settle_detect_soft_travel_limit_test
`default_nettype wire
